// file: logic/csr_pkg.sv
// Package: register map, field layout and reset values of the status readback block
package csr_pkg;
  // ---------------------------------------------------------------
  // Access word layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned RW_BIT        = 15;
  localparam int unsigned ADDR_MSB      = 14;
  localparam int unsigned ADDR_LSB      = 9;
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned RSVD_BIT      = 8;
  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [5:0]  STATUS_ADDR   = 6'h08;
  localparam logic [5:0]  OVR_A_ADDR    = 6'h0A;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] OVR_A_RESET   = 16'h1400;
  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int unsigned CH_A_MSB      = 15;
  localparam int unsigned CH_A_LSB      = 12;
  localparam int unsigned CH_B_MSB      = 11;
  localparam int unsigned CH_B_LSB      = 8;
  localparam int unsigned CRC_MSB       = 7;
  localparam int unsigned CRC_LSB       = 0;
  localparam int unsigned CH_IDX_W      = 4;
  localparam int unsigned CRC_W         = 8;
  localparam int unsigned OVR_CH_N      = 8;
endpackage

// file: logic/csr_status_bank.sv
// Module: conversion status readback and group A over-range control registers
`timescale 1ns/1ps
// Summary of operation
// RULE1: Status bits 15..12 read back the channel index last converted by converter A.
// RULE2: Status bits 11..8 read back the channel index last converted by converter B.
// RULE3: Status bits 7..0 read back the latest 8-bit CRC result.
// RULE4: The status register sits at address 0x8 and resets to zero.
// RULE5: The group A over-range register sits at address 0xA and resets to 0x1400.
// RULE6: The host sets bit 15 of an access word to 0 for a read and 1 for a write.
// RULE7: The host puts the 6-bit register address in bits 14..9 of the access word.
// RULE8: An over-range bit of 1 widens that channel's range by 20 percent, 0 keeps it.
// RULE9: Reserved bit 8 ignores writes and reads as zero.
// RULE10: Both channel indexes update together per conversion, the CRC per new result.
module csr_status_bank
  import csr_pkg::*;
(
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         access_valid_in,
  input  wire logic [csr_pkg::WORD_W-1:0]   access_word_in,
  input  wire logic                         conv_done_in,
  input  wire logic [csr_pkg::CH_IDX_W-1:0] conv_channel_a_in,
  input  wire logic [csr_pkg::CH_IDX_W-1:0] conv_channel_b_in,
  input  wire logic                         crc_valid_in,
  input  wire logic [csr_pkg::CRC_W-1:0]    crc_value_in,
  output logic                              read_valid_out,
  output logic [csr_pkg::WORD_W-1:0]        read_data_out,
  output logic [csr_pkg::OVR_CH_N-1:0]      overrange_enable_out
);
  import csr_pkg::*;

  // ---------------------------------------------------------------
  // Access word decode
  // ---------------------------------------------------------------
  logic [CH_IDX_W-1:0] chan_a_reg;
  logic [CH_IDX_W-1:0] chan_b_reg;
  logic [CRC_W-1:0]    crc_reg;
  logic [OVR_CH_N-1:0] ovr_a_reg;
  wire  logic          is_write;
  wire  logic [ADDR_W-1:0] register_address_field;
  wire  logic          hit_status;
  wire  logic          hit_ovr_a;
  wire  logic          rd_req;
  wire  logic          wr_req;
  wire  logic [WORD_W-1:0] status_word;
  wire  logic [WORD_W-1:0] ovr_a_word;
  wire  logic [WORD_W-1:0] read_next;

  assign is_write               = access_word_in[RW_BIT];             // [RULE6]
  assign register_address_field = access_word_in[ADDR_MSB:ADDR_LSB];  // [RULE7]
  assign hit_status             = register_address_field == STATUS_ADDR; // [RULE4]
  assign hit_ovr_a              = register_address_field == OVR_A_ADDR;  // [RULE5]
  assign rd_req                 = access_valid_in && !is_write;         // [RULE6]
  assign wr_req                 = access_valid_in && is_write;          // [RULE6]

  // Address field echoes back in the over-range word; bit 8 is tied low
  assign status_word = {chan_a_reg, chan_b_reg, crc_reg};             // [RULE1] [RULE2] [RULE3]
  assign ovr_a_word  = {1'b0, OVR_A_ADDR, 1'b0, ovr_a_reg};           // [RULE9]
  // Unmapped addresses read as zero so a stray read is harmless
  assign read_next   = hit_status ? status_word :
                       hit_ovr_a  ? ovr_a_word  : 16'h0000;

  // ---------------------------------------------------------------
  // Status capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      chan_a_reg <= STATUS_RESET[CH_A_MSB:CH_A_LSB];                  // [RULE4]
      chan_b_reg <= STATUS_RESET[CH_B_MSB:CH_B_LSB];
      crc_reg    <= STATUS_RESET[CRC_MSB:CRC_LSB];
    end
    else
    begin
      // Both indexes move in the same edge so a read never sees a mixed pair
      if (conv_done_in)
      begin
        chan_a_reg <= conv_channel_a_in;                              // [RULE10]
        chan_b_reg <= conv_channel_b_in;                              // [RULE10]
      end
      if (crc_valid_in)
        crc_reg <= crc_value_in;                                      // [RULE10]
    end
  end

  // ---------------------------------------------------------------
  // Over-range control and read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ovr_a_reg            <= OVR_A_RESET[OVR_CH_N-1:0];              // [RULE5]
      overrange_enable_out <= OVR_A_RESET[OVR_CH_N-1:0];
      read_valid_out       <= 1'b0;
      read_data_out        <= 16'h0000;
    end
    else
    begin
      // Status is read-only: writes to it fall through untouched
      if (wr_req && hit_ovr_a)
        ovr_a_reg <= access_word_in[OVR_CH_N-1:0];                    // [RULE9]
      overrange_enable_out <= ovr_a_reg;                              // [RULE8]
      read_valid_out       <= rd_req;                                 // [RULE6]
      if (rd_req)
        read_data_out <= read_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_status_read;
    access_valid_in && !is_write && hit_status;
  endsequence

  sequence s_ovr_write;
    wr_req && hit_ovr_a;
  endsequence

  sequence s_unmapped_read;
    rd_req && !hit_status && !hit_ovr_a;
  endsequence

  // CRC strobe, one quiet cycle, then a status read: the shortest host turnaround
  sequence s_crc_then_read;
    crc_valid_in ##1 !crc_valid_in ##1 (rd_req && hit_status && !crc_valid_in);
  endsequence

  property p_status_chan_a;
    @(posedge clk_in) disable iff (!arst_n_in)
    s_status_read |=> read_data_out[CH_A_MSB:CH_A_LSB] == $past(chan_a_reg);
  endproperty
  a_status_chan_a: assert property (p_status_chan_a) else $error("chan A field wrong"); // [RULE1]

  property p_status_chan_b;
    @(posedge clk_in) disable iff (!arst_n_in)
    s_status_read |=> read_data_out[CH_B_MSB:CH_B_LSB] == $past(chan_b_reg);
  endproperty
  a_status_chan_b: assert property (p_status_chan_b) else $error("chan B field wrong"); // [RULE2]

  property p_status_crc;
    @(posedge clk_in) disable iff (!arst_n_in)
    s_crc_then_read |=> read_data_out[CRC_MSB:CRC_LSB] == $past(crc_value_in, 3);
  endproperty
  a_status_crc: assert property (p_status_crc) else $error("crc field wrong"); // [RULE3]

  property p_status_ro;
    @(posedge clk_in) disable iff (!arst_n_in)
    (access_valid_in && is_write && hit_status && !conv_done_in && !crc_valid_in)
      |=> $stable(chan_a_reg) && $stable(chan_b_reg) && $stable(crc_reg);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status written"); // [RULE4]

  property p_ovr_write;
    @(posedge clk_in) disable iff (!arst_n_in)
    (access_valid_in && is_write && hit_ovr_a)
      |=> ##1 overrange_enable_out == $past(access_word_in[OVR_CH_N-1:0], 2);
  endproperty
  a_ovr_write: assert property (p_ovr_write) else $error("overrange not applied"); // [RULE8]

  property p_rsvd_zero;
    @(posedge clk_in) disable iff (!arst_n_in)
    read_valid_out |-> read_data_out[RSVD_BIT] == 1'b0 || $past(hit_status);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // [RULE9]

  property p_read_pulse;
    @(posedge clk_in) disable iff (!arst_n_in)
    (access_valid_in && !is_write) |=> read_valid_out;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read not answered"); // [RULE6]

  property p_ovr_addr_echo;
    @(posedge clk_in) disable iff (!arst_n_in)
    (access_valid_in && !is_write && hit_ovr_a)
      |=> read_data_out[ADDR_MSB:ADDR_LSB] == OVR_A_ADDR && !read_data_out[RW_BIT];
  endproperty
  a_ovr_addr_echo: assert property (p_ovr_addr_echo) else $error("address echo wrong"); // [RULE7]

  property p_pair_update;
    @(posedge clk_in) disable iff (!arst_n_in)
    conv_done_in |=> chan_a_reg == $past(conv_channel_a_in)
                     && chan_b_reg == $past(conv_channel_b_in);
  endproperty
  a_pair_update: assert property (p_pair_update) else $error("index pair split"); // [RULE10]

  // Writes carry no answer, so a host polling for a read pulse never sees a stale one
  property p_write_silent;
    @(posedge clk_in) disable iff (!arst_n_in)
    wr_req |=> !read_valid_out;
  endproperty
  a_write_silent: assert property (p_write_silent) else $error("write answered"); // [RULE6]

  property p_read_data_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
    !rd_req |=> $stable(read_data_out);
  endproperty
  a_read_data_hold: assert property (p_read_data_hold) else $error("read data moved"); // [RULE6]

  property p_unmapped_zero;
    @(posedge clk_in) disable iff (!arst_n_in)
    s_unmapped_read |=> read_data_out == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero"); // [RULE7]

  property p_ovr_store;
    @(posedge clk_in) disable iff (!arst_n_in)
    s_ovr_write |=> ovr_a_reg == $past(access_word_in[OVR_CH_N-1:0]);
  endproperty
  a_ovr_store: assert property (p_ovr_store) else $error("overrange write lost"); // [RULE9]

  property p_ovr_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
    !(wr_req && hit_ovr_a) |=> $stable(ovr_a_reg);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrange changed unasked"); // [RULE8]

  property p_index_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
    !conv_done_in |=> $stable(chan_a_reg) && $stable(chan_b_reg);
  endproperty
  a_index_hold: assert property (p_index_hold) else $error("index moved idle"); // [RULE10]

  property p_crc_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
    !crc_valid_in |=> $stable(crc_reg);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc moved idle"); // [RULE10]

  property p_crc_capture;
    @(posedge clk_in) disable iff (!arst_n_in)
    crc_valid_in |=> crc_reg == $past(crc_value_in);
  endproperty
  a_crc_capture: assert property (p_crc_capture) else $error("crc not captured"); // [RULE3]

  // First edge after release: nothing could have moved yet, so reset values must show
  property p_reset_status;
    @(posedge clk_in)
    $rose(arst_n_in) |-> {chan_a_reg, chan_b_reg, crc_reg} == STATUS_RESET
                         && !read_valid_out && read_data_out == 16'h0000;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status reset wrong"); // [RULE4]

  property p_reset_ovr;
    @(posedge clk_in)
    $rose(arst_n_in) |-> ovr_a_reg == OVR_A_RESET[OVR_CH_N-1:0]
                         && overrange_enable_out == OVR_A_RESET[OVR_CH_N-1:0];
  endproperty
  a_reset_ovr: assert property (p_reset_ovr) else $error("overrange reset wrong"); // [RULE5]
endmodule

// file: verification/csr_host_model.sv
// Host controller model issuing register access words
`timescale 1ns/1ps
module csr_host_model
  import csr_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       read_valid_in,
  input  wire logic [csr_pkg::WORD_W-1:0] read_data_in,
  output logic                            access_valid_out,
  output logic [csr_pkg::WORD_W-1:0]      access_word_out
);
  initial
  begin
    access_valid_out = 1'b0;
    access_word_out  = 16'h0000;
  end
  // Writes set reserved bit 8 so the device must drop it
  task automatic access(input logic wr, input logic [5:0] adr, input logic [7:0] dat,
                        output logic [15:0] rdat, output bit ok);
    @(posedge clk_in);
    #2;
    access_valid_out = 1'b1;
    access_word_out  = {wr, adr, wr, dat};
    @(posedge clk_in);
    #2;
    access_valid_out = 1'b0;
    // Released word inverted so a stale value never reads as fresh
    access_word_out  = ~access_word_out;
    ok               = wr | (read_valid_in === 1'b1);
    rdat             = read_data_in;
  endtask
endmodule

// file: verification/conversion_status_readback_test.sv
// Self-checking bench for the status readback register block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module conversion_status_readback_test;
  import csr_pkg::*;
  logic        clk_in, arst_n_in, conv_done_in, crc_valid_in, acc_valid, rd_valid;
  logic [3:0]  ch_a, ch_b;
  logic [7:0]  crc, ovr_en, exp_ovr;
  logic [15:0] word, rdata, got, seed, exp_stat;
  int          bad_count, total_checks;
  bit          ok;
  csr_status_bank csr_status_bank_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .access_valid_in(acc_valid), .access_word_in(word), .conv_done_in(conv_done_in),
    .conv_channel_a_in(ch_a), .conv_channel_b_in(ch_b), .crc_valid_in(crc_valid_in),
    .crc_value_in(crc), .read_valid_out(rd_valid), .read_data_out(rdata),
    .overrange_enable_out(ovr_en));
  csr_host_model csr_host_model_i (.clk_in(clk_in), .read_valid_in(rd_valid),
    .read_data_in(rdata), .access_valid_out(acc_valid), .access_word_out(word));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ovr_exp(input logic [7:0] d);
    return {1'b0, OVR_A_ADDR, 1'b0, d};
  endfunction
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e, input string nm);
    csr_host_model_i.access(1'b0, a, 8'h00, got, ok);
    `CHK("read_answer", 1'b1, ok)
    if (!ok)
      conclude();
    `CHK(nm, e, got)
  endtask
  task automatic do_reset();
    arst_n_in = 1'b0;
    exp_stat  = 16'h0000;
    repeat (16) @(posedge clk_in);
    #2;
    arst_n_in = 1'b1;
  endtask
  // Random indexes and CRC; either strobe may be absent to prove the fields are independent
  task automatic conv(input logic dc, input logic cv);
    @(posedge clk_in);
    #2;
    seed               = lfsr(seed);
    {ch_a, ch_b, crc}  = seed;
    conv_done_in       = dc;
    crc_valid_in       = cv;
    if (dc)
      exp_stat[15:8] = seed[15:8];
    if (cv)
      exp_stat[7:0] = seed[7:0];
    @(posedge clk_in);
    #2;
    conv_done_in      = 1'b0;
    crc_valid_in      = 1'b0;
    {ch_a, ch_b, crc} = ~seed;
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    conclude();
  end
  initial
  begin
    seed              = 16'hFA1B;
    conv_done_in      = 1'b0;
    crc_valid_in      = 1'b0;
    {ch_a, ch_b, crc} = 16'h0000;
    do_reset();
    rd(STATUS_ADDR, 16'h0000, "status_reset");
    rd(OVR_A_ADDR, ovr_exp(8'h00), "ovr_reset");
    for (int i = 0; i < 20; i++)
    begin
      conv(i % 3 != 2, i % 2 == 0);
      rd(STATUS_ADDR, exp_stat, "status_fields");
    end
    for (int i = 0; i < 8; i++)
    begin
      seed    = lfsr(seed);
      exp_ovr = (i == 0) ? 8'hFF : seed[7:0];
      csr_host_model_i.access(1'b1, OVR_A_ADDR, exp_ovr, got, ok);
      `CHK("write_silent", 1'b0, rd_valid)
      @(posedge clk_in);
      #2;
      `CHK("ovr_enable", exp_ovr, ovr_en)
      rd(OVR_A_ADDR, ovr_exp(exp_ovr), "ovr_readback");
    end
    csr_host_model_i.access(1'b1, STATUS_ADDR, 8'h5A, got, ok);
    rd(STATUS_ADDR, exp_stat, "status_read_only");
    rd(6'h3F, 16'h0000, "unmapped_read");
    do_reset();
    `CHK("ovr_after_reset", 8'h00, ovr_en)
    rd(STATUS_ADDR, 16'h0000, "status_rereset");
    conclude();
  end
endmodule
